// ==== verilog/alu_decode_defines.svh ====
// Offsets, opcodes, field positions and timing counts for the decode block
`ifndef ALU_DECODE_DEFINES_SVH
`define ALU_DECODE_DEFINES_SVH

// APB register byte offsets
`define REG_CTRL      12'h000
`define REG_WORK      12'h004
`define REG_STATUS    12'h008
`define REG_BANK      12'h00C
`define REG_TBL_PTR   12'h010
`define REG_TBL_LATCH 12'h014
`define REG_PROD      12'h018
`define REG_PC        12'h01C
`define REG_PTR0      12'h020
`define REG_PTR1      12'h024
`define REG_PTR2      12'h028

// Reset values
`define RESET_BYTE    8'h00
`define RESET_PC      21'h000000

// Literal and branch opcodes, instruction bits 15:8
`define OP_ADD_LIT    8'h0F
`define OP_AND_LIT    8'h0B
`define OP_OR_LIT     8'h09
`define OP_XOR_LIT    8'h0A
`define OP_SUB_LIT    8'h08
`define OP_MOVE_LIT   8'h0E
`define OP_MUL_LIT    8'h0D
`define OP_RET_LIT    8'h0C
`define OP_BR_CARRY   8'hE2
`define OP_BR_NEG     8'hE6
// Opcode fields of other widths
`define OP_BANK_LOAD  12'h010
`define OP_PTR_LOAD   10'h3B8
`define OP_TBL_RD     14'h0002
`define OP_TBL_WR     14'h0003
`define OP_ADD_REG    6'h09
`define OP_ADDC_REG   6'h08
`define OP_AND_REG    6'h05
`define OP_BIT_CLR    4'h9
`define OP_SECOND     4'hF

// Table pointer update modes, instruction bits 1:0
`define TBL_POST_INC  2'b01
`define TBL_POST_DEC  2'b10
`define TBL_PRE_INC   2'b11

// Data space addresses and access bank split
`define PORT_B_ADDR   12'hF81
`define TIMER_ZERO    12'hFD6
`define ACCESS_SPLIT  8'h80
`define ACCESS_HIGH   4'hF
`define ACCESS_LOW    4'h0

// Timing: four phases per cycle, three extra cycles for a memory write
`define LAST_PHASE    2'd3
`define TBL_EXTRA     2'd2
`endif

// ==== verilog/alu_decode_pkg.sv ====
// Types shared by the instruction decode block
package alu_decode_pkg;
  typedef enum logic [1:0] {EXEC, DEAD, PTR_LOW, TBL_WAIT} cycle_type;
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic digit;
    logic carry;
  } status_type;
  typedef struct packed {
    status_type flags;
    logic [7:0] sum;
  } alu_out_type;
endpackage

// ==== verilog/literal_table_alu_branch_decode.sv ====
// Decode and execute core for literal, table, register ALU and branch ops
`timescale 1ns/1ps
`include "alu_decode_defines.svh"

// Contract
// - PC change or true test costs two cycles
// - Directly reached second word acts as NOP
// - Port read-modify uses pin values as source
// - Timer count write clears assigned prescaler
// - Started table memory write runs to end
// - Add literal to working reg, five flags
// - Literal AND, OR, XOR set zero, negative
// - Literal minus working reg, five flags
// - Move literal to working reg, flags kept
// - Literal multiply in one cycle, flags kept
// - Bank load writes low four bank bits
// - Pointer load: two words, 12-bit literal
// - Return literal: load, return, two cycles
// - Table read two cycles, four pointer modes
// - Table write two cycles, five with write
// - Destination bit picks working or file reg
// - Access bit zero forces the access bank
// - Register add, destination routed, five flags
// - Add with carry, destination routed, five flags
// - Register AND sets only negative and zero
// - Taken branch adds two plus twice offset
// - Branch on carry set or negative set
// - Bit clear by 3-bit position, flags kept
// - 21-bit table pointer, 8-bit table latch
module literal_table_alu_branch_decode
  import alu_decode_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] instrWord,
  output logic      [20:0] progAddr,
  input  wire logic [20:0] stackTop,
  output logic             stackPop,
  output logic      [11:0] fileAddr,
  input  wire logic [7:0]  fileRdata,
  output logic      [7:0]  fileWdata,
  output logic             fileWe,
  input  wire logic [7:0]  portPins,
  input  wire logic        prescalerAssigned,
  output logic             prescalerClear,
  output logic      [20:0] tableAddr,
  input  wire logic [7:0]  tableRdata,
  output logic      [7:0]  tableWdata,
  output logic             tableRd,
  output logic             tableWr,
  input  wire logic        tableWriteStarted
);

  logic [1:0]  q;
  cycle_type   state;
  logic [15:0] ir;
  logic [7:0]  working_register;
  logic [7:0]  opnd;
  logic [7:0]  table_latch;
  status_type  status;
  logic [3:0]  bank_select_register;
  logic [20:0] pc;
  logic [20:0] table_pointer;
  logic [15:0] prod;
  logic [11:0] fsr [0:3];
  logic [1:0]  waitCnt;
  logic [3:0]  ptrHigh;
  logic [1:0]  ptrSel;
  logic        ctrlRun;

  function automatic alu_out_type addFn(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
    logic [8:0]  s;
    logic [4:0]  h;
    alu_out_type r;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.sum = s[7:0];
    r.flags.carry = s[8];
    r.flags.digit = h[4];
    r.flags.zero = (s[7:0] == 8'h00);
    r.flags.neg = s[7];
    r.flags.ovf = (a[7] == b[7]) && (s[7] != a[7]);
    return r;
  endfunction

  function automatic status_type nzFlags(input logic [7:0] v,
                                         input status_type s);
    status_type r;
    r = s;
    r.neg = v[7];
    r.zero = (v == 8'h00);
    return r;
  endfunction

  function automatic logic [11:0] bankAddr(input logic [7:0] f,
                                           input logic       acc,
                                           input logic [3:0] bank);
    logic [3:0] hi;
    hi = (f >= `ACCESS_SPLIT) ? `ACCESS_HIGH : `ACCESS_LOW;
    return acc ? {bank, f} : {hi, f};
  endfunction

  // Opcode decode
  wire isAddLit  = ir[15:8] == `OP_ADD_LIT;
  wire isAndLit  = ir[15:8] == `OP_AND_LIT;
  wire isOrLit   = ir[15:8] == `OP_OR_LIT;
  wire isXorLit  = ir[15:8] == `OP_XOR_LIT;
  wire isSubLit  = ir[15:8] == `OP_SUB_LIT;
  wire isMoveLit = ir[15:8] == `OP_MOVE_LIT;
  wire isMulLit  = ir[15:8] == `OP_MUL_LIT;
  wire isRetLit  = ir[15:8] == `OP_RET_LIT;
  wire isBankLd  = ir[15:4] == `OP_BANK_LOAD;
  wire isPtrLd   = ir[15:6] == `OP_PTR_LOAD;
  wire isTblRd   = ir[15:2] == `OP_TBL_RD;
  wire isTblWr   = ir[15:2] == `OP_TBL_WR;
  wire isAddReg  = ir[15:10] == `OP_ADD_REG;
  wire isAddcReg = ir[15:10] == `OP_ADDC_REG;
  wire isAndReg  = ir[15:10] == `OP_AND_REG;
  wire isBitClr  = ir[15:12] == `OP_BIT_CLR;
  wire isBrCarry = ir[15:8] == `OP_BR_CARRY;
  wire isBrNeg   = ir[15:8] == `OP_BR_NEG;
  wire isSecond  = ir[15:12] == `OP_SECOND;
  wire usesFile  = isAddReg | isAddcReg | isAndReg | isBitClr;
  wire destFile  = isBitClr | ir[9];
  wire isTbl     = isTblRd | isTblWr;
  wire exec4     = ctrlRun && (q == `LAST_PHASE) && (state == EXEC);
  wire phaseEnd  = ctrlRun && (q == `LAST_PHASE);

  wire [11:0] fileSel = bankAddr(ir[7:0], ir[8], bank_select_register);
  wire readsPort = fileAddr == `PORT_B_ADDR;
  wire brTaken = (isBrCarry & status.carry) |
                 (isBrNeg & status.neg);
  wire [20:0] brTarget = pc + 21'd2 +
                 {{12{ir[7]}}, ir[7:0], 1'b0};
  wire [20:0] tblNow = (ir[1:0] == `TBL_PRE_INC) ?
                 table_pointer + 21'd1 : table_pointer;

  wire alu_out_type aluAdd = addFn(working_register, ir[7:0], 1'b0);
  wire alu_out_type aluSub = addFn(ir[7:0], ~working_register, 1'b1);
  wire alu_out_type aluReg = addFn(working_register, opnd,
                 isAddcReg & status.carry);
  wire [7:0] litLogic = isAndLit ? (working_register & ir[7:0]) :
                        isOrLit  ? (working_register | ir[7:0]) :
                                   (working_register ^ ir[7:0]);
  wire [7:0] bitMask = 8'h01 << ir[11:9];
  wire [7:0] regRes = isAndReg ? (working_register & opnd) :
                      isBitClr ? (opnd & ~bitMask) : aluReg.sum;
  wire status_type regFlags = isAndReg ? nzFlags(regRes, status) :
                              aluReg.flags;

  logic [7:0]  next_working_register;
  status_type  next_status;
  logic [20:0] next_pc;
  cycle_type   next_state;
  logic        next_we;
  logic [3:0]  next_bsr;
  logic [15:0] next_prod;

  always_comb begin
    next_working_register = working_register;
    next_status = status;
    next_pc = pc + 21'd2;
    next_state = EXEC;
    next_we = 1'b0;
    next_bsr = bank_select_register;
    next_prod = prod;
    case (state)
      EXEC: begin
        if (isAddLit) begin
          next_working_register = aluAdd.sum;
          next_status = aluAdd.flags;
        end else if (isSubLit) begin
          next_working_register = aluSub.sum;
          next_status = aluSub.flags;
        end else if (isAndLit | isOrLit | isXorLit) begin
          next_working_register = litLogic;
          next_status = nzFlags(litLogic, status);
        end else if (isMoveLit) begin
          next_working_register = ir[7:0];
        end else if (isMulLit) begin
          next_prod = {8'h00, working_register} * {8'h00, ir[7:0]};
        end else if (isBankLd) begin
          next_bsr = ir[3:0];
        end else if (isRetLit) begin
          next_working_register = ir[7:0];
          next_pc = stackTop;
          next_state = DEAD;
        end else if (isPtrLd) begin
          next_state = PTR_LOW;
        end else if (isTbl) begin
          next_state = DEAD;
        end else if (usesFile) begin
          if (destFile) begin
            next_we = 1'b1;
          end else begin
            next_working_register = regRes;
          end
          if (!isBitClr) begin
            next_status = regFlags;
          end
        end else if (brTaken) begin
          next_pc = brTarget;
          next_state = DEAD;
        end
        // A stray second word falls through as a plain NOP
      end
      DEAD: begin
        next_pc = pc;
        if (isTblWr && tableWriteStarted) begin
          next_state = TBL_WAIT;
        end
      end
      PTR_LOW: begin
        next_state = EXEC;
      end
      default: begin
        next_pc = pc;
        // Never aborted: the memory write is left to finish
        next_state = (waitCnt == 2'd0) ? EXEC : TBL_WAIT;
      end
    endcase
  end

  // Phase counter stalls while the core is halted
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= 2'd0;
    end else if (ctrlRun) begin
      q <= q + 2'd1;
    end
  end

  // Q1 decode, Q2 operand address, Q3 operand capture
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ir <= 16'h0000;
      fileAddr <= 12'h000;
      opnd <= `RESET_BYTE;
    end else if (ctrlRun) begin
      if (q == 2'd0 && state == EXEC) begin
        ir <= instrWord;
      end
      if (q == 2'd1) begin
        fileAddr <= fileSel;
      end
      if (q == 2'd2) begin
        opnd <= readsPort ? portPins : fileRdata;
      end
    end
  end

  // Q4 write back
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= EXEC;
      pc <= `RESET_PC;
      progAddr <= `RESET_PC;
      status <= '0;
      bank_select_register <= 4'h0;
      prod <= 16'h0000;
      fileWe <= 1'b0;
      fileWdata <= `RESET_BYTE;
      stackPop <= 1'b0;
      prescalerClear <= 1'b0;
      waitCnt <= 2'd0;
    end else begin
      fileWe <= 1'b0;
      stackPop <= 1'b0;
      prescalerClear <= 1'b0;
      if (phaseEnd) begin
        state <= next_state;
        pc <= next_pc;
        progAddr <= next_pc;
        status <= next_status;
        bank_select_register <= next_bsr;
        prod <= next_prod;
        fileWe <= next_we;
        fileWdata <= regRes;
        stackPop <= exec4 && isRetLit;
        prescalerClear <= next_we && prescalerAssigned &&
                          fileAddr == `TIMER_ZERO;
        if (state == TBL_WAIT) begin
          waitCnt <= waitCnt - 2'd1;
        end else begin
          waitCnt <= `TBL_EXTRA;
        end
      end
    end
  end

  // Pointer load: upper bits from word one, low byte from word two
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ptrHigh <= 4'h0;
      ptrSel <= 2'd0;
      for (int i = 0; i < 4; i++) begin
        fsr[i] <= 12'h000;
      end
    end else if (phaseEnd) begin
      if (state == EXEC && isPtrLd) begin
        ptrHigh <= ir[3:0];
        ptrSel <= ir[5:4];
      end
      if (state == PTR_LOW) begin
        fsr[ptrSel] <= {ptrHigh, instrWord[7:0]};
      end
    end
  end

  // Table unit; software may preload pointer and latch while halted
  wire apbWr = psel && penable && pready && pwrite;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      table_pointer <= `RESET_PC;
      table_latch <= `RESET_BYTE;
      tableAddr <= `RESET_PC;
      tableWdata <= `RESET_BYTE;
      tableRd <= 1'b0;
      tableWr <= 1'b0;
    end else begin
      tableRd <= 1'b0;
      tableWr <= 1'b0;
      if (exec4 && isTbl) begin
        tableAddr <= tblNow;
        tableWdata <= table_latch;
        tableRd <= isTblRd;
        tableWr <= isTblWr;
        table_pointer <= tblNow;
      end else if (phaseEnd && state == DEAD && isTbl) begin
        if (isTblRd) begin
          table_latch <= tableRdata;
        end
        if (ir[1:0] == `TBL_POST_INC) begin
          table_pointer <= table_pointer + 21'd1;
        end else if (ir[1:0] == `TBL_POST_DEC) begin
          table_pointer <= table_pointer - 21'd1;
        end
      end else if (apbWr && !ctrlRun) begin
        if (paddr == `REG_TBL_PTR) begin
          table_pointer <= pwdata[20:0];
        end else if (paddr == `REG_TBL_LATCH) begin
          table_latch <= pwdata[7:0];
        end
      end
    end
  end

  // Working register: core when running, APB only when halted
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      working_register <= `RESET_BYTE;
    end else if (phaseEnd) begin
      working_register <= next_working_register;
    end else if (apbWr && !ctrlRun && paddr == `REG_WORK) begin
      working_register <= pwdata[7:0];
    end
  end

  // APB slave: one wait state, then the answer
  wire mapped = paddr == `REG_CTRL || paddr == `REG_WORK ||
                paddr == `REG_STATUS || paddr == `REG_BANK ||
                paddr == `REG_TBL_PTR || paddr == `REG_TBL_LATCH ||
                paddr == `REG_PROD || paddr == `REG_PC ||
                paddr == `REG_PTR0 || paddr == `REG_PTR1 ||
                paddr == `REG_PTR2;
  wire [31:0] rdMux =
    paddr == `REG_CTRL      ? {31'h0, ctrlRun} :
    paddr == `REG_WORK      ? {24'h0, working_register} :
    paddr == `REG_STATUS    ? {27'h0, status} :
    paddr == `REG_BANK      ? {28'h0, bank_select_register} :
    paddr == `REG_TBL_PTR   ? {11'h0, table_pointer} :
    paddr == `REG_TBL_LATCH ? {24'h0, table_latch} :
    paddr == `REG_PROD      ? {16'h0, prod} :
    paddr == `REG_PC        ? {11'h0, pc} :
    paddr == `REG_PTR0      ? {20'h0, fsr[0]} :
    paddr == `REG_PTR1      ? {20'h0, fsr[1]} :
    paddr == `REG_PTR2      ? {20'h0, fsr[2]} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrlRun <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && !pwrite) ? rdMux : 32'h0;
      // Halting only at a cycle boundary keeps phases aligned
      if (apbWr && paddr == `REG_CTRL && (q == 2'd0 || !ctrlRun)) begin
        ctrlRun <= pwdata[0];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seqBranchTake;
    exec4 && !isTbl && !isRetLit && !isPtrLd && !usesFile && brTaken;
  endsequence
  sequence seqDeadCycle;
    state == DEAD [*4];
  endsequence

  chk_branch_dead: assert property (
    seqBranchTake |=> seqDeadCycle ##1 state == EXEC)
    else $error("taken branch did not spend one dead cycle");
  chk_second_nop: assert property (
    exec4 && isSecond |=> working_register == $past(working_register) && !fileWe)
    else $error("stray second word changed state");
  chk_port_source: assert property (
    ctrlRun && q == 2'd2 && readsPort |=> opnd == $past(portPins))
    else $error("port operand not taken from pins");
  chk_prescale_clear: assert property (
    exec4 && usesFile && destFile && prescalerAssigned &&
    fileAddr == `TIMER_ZERO |=> prescalerClear && fileWe)
    else $error("timer write missed prescaler clear");
  chk_tbl_wait: assert property (
    phaseEnd && state == DEAD && isTblWr && tableWriteStarted
    |=> state == TBL_WAIT)
    else $error("started table write not extended");
  chk_add_lit: assert property (
    exec4 && isAddLit |=> working_register == 8'($past(working_register) + $past(ir[7:0])))
    else $error("add literal result wrong");
  chk_move_flags: assert property (
    exec4 && isMoveLit
    |=> status == $past(status) && working_register == $past(ir[7:0]))
    else $error("move literal changed flags or value");
  chk_bank_load: assert property (
    exec4 && isBankLd |=> bank_select_register == $past(ir[3:0]))
    else $error("bank load wrong");
  chk_bit_clear: assert property (
    exec4 && isBitClr |=> fileWe &&
    fileWdata == ($past(opnd) & ~(8'h01 << $past(ir[11:9]))))
    else $error("bit clear result wrong");
  chk_branch_target: assert property (
    seqBranchTake |=> pc == 21'($past(pc) + 21'd2 +
      {{12{$past(ir[7])}}, $past(ir[7:0]), 1'b0}))
    else $error("branch target wrong");

endmodule

// ==== verif/prog_data_model.sv ====
// Program memory, data file and table memory facing the decode core
`timescale 1ns/1ps
module prog_data_model (
  input  wire logic        ref_clk,
  input  wire logic [20:0] progAddr,
  output logic      [15:0] instrWord,
  input  wire logic [11:0] fileAddr,
  output logic      [7:0]  fileRdata,
  input  wire logic [7:0]  fileWdata,
  input  wire logic        fileWe,
  input  wire logic [20:0] tableAddr,
  output logic      [7:0]  tableRdata,
  input  wire logic [7:0]  tableWdata,
  input  wire logic        tableRd,
  input  wire logic        tableWr
);
  logic [15:0] pmem [0:2047];
  logic [7:0]  dmem [0:4095];
  logic [7:0]  tbl  [0:255];
  logic [2:0]  hold;
  assign instrWord = pmem[progAddr[11:1]];
  initial begin
    hold = 3'h0;
    tableRdata = 8'h00;
    for (int i = 0; i < 2048; i++) pmem[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) dmem[i] = 8'h00;
    for (int i = 0; i < 256; i++) tbl[i] = 8'(i) ^ 8'h5A;
  end
  // Reads are combinational: the core captures one clock after the address
  assign fileRdata = dmem[fileAddr];
  always @(posedge ref_clk) begin
    if (fileWe) dmem[fileAddr] <= fileWdata;
  end
  // Data is held only for the promised window, then scrambled
  always @(posedge ref_clk) begin
    if (tableRd) begin
      tableRdata <= tbl[tableAddr[7:0]];
      hold <= 3'h5;
    end else if (hold != 3'h0) hold <= hold - 3'h1;
    else tableRdata <= ~tableRdata;
    if (tableWr) tbl[tableAddr[7:0]] <= tableWdata;
  end
endmodule

// ==== verif/literal_table_alu_branch_decode_tb.sv ====
// Self-checking bench for the literal, table, ALU and branch core
`timescale 1ns/1ps
`include "alu_decode_defines.svh"
module literal_table_alu_branch_decode_tb;
  typedef struct {
    logic [15:0] op;
    logic [11:0] fa;
    logic [7:0]  f0, w0;
    logic [4:0]  s0;
    logic [7:0]  we, fe;
    logic [4:0]  se;
  } row_type;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic        pready, pslverr, lastErr;
  logic [15:0] instrWord;
  logic [20:0] progAddr, tableAddr, firstPc;
  logic [20:0] stackTop = 21'h000040;
  logic        stackPop, fileWe, prescalerClear, tableRd, tableWr;
  logic [11:0] fileAddr;
  logic [7:0]  fileRdata, fileWdata, tableRdata, tableWdata;
  logic [7:0]  portPins = 8'h0F;
  logic        prescalerAssigned = 1'b0, tableWriteStarted = 1'b0;
  int          err_count = 0, check_count = 0, gap, clrPulses, cycles = 0;
  int          popPulses = 0;
  row_type     rows [15];
  logic [15:0] brOp [4] = '{16'hE203, 16'hE203, 16'hE67F, 16'hE67F};
  logic [4:0]  brSt [4] = '{5'h01, 5'h10, 5'h10, 5'h01};
  logic [31:0] brPc [4] = '{32'h10, 32'hA, 32'h108, 32'hA};
  int          brGap [4] = '{8, 4, 8, 4};
  logic [31:0] ptrExp [4] = '{32'h0, 32'h1, 32'h1FFFFF, 32'h1};
  logic [15:0] tmOp [3] = '{16'h26D6, 16'h24D6, 16'h26D6};
  logic        tmAs [3] = '{1'b1, 1'b1, 1'b0};
  int          tmExp [3] = '{1, 0, 0};

  always #10 ref_clk = ~ref_clk;

  literal_table_alu_branch_decode u_dut (
    .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .instrWord, .progAddr, .stackTop,
    .stackPop, .fileAddr, .fileRdata, .fileWdata, .fileWe, .portPins,
    .prescalerAssigned, .prescalerClear, .tableAddr, .tableRdata,
    .tableWdata, .tableRd, .tableWr, .tableWriteStarted
  );
  prog_data_model u_mem (
    .ref_clk, .progAddr, .instrWord, .fileAddr, .fileRdata, .fileWdata,
    .fileWe, .tableAddr, .tableRdata, .tableWdata, .tableRd, .tableWr
  );

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole run needs under two thousand clocks
  always @(posedge ref_clk) begin
    cycles++;
    if (prescalerClear === 1'b1) clrPulses++;
    if (stackPop === 1'b1) popPulses++;
    if (cycles == 10000) begin
      err_count++;
      $display("Timeout after %0d cycles", cycles);
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input string name,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rdData);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask

  // Literal pair whose add leaves the wanted flags behind
  function automatic logic [15:0] flagPair(input logic [4:0] s);
    case (s)
      5'h01: return 16'hF020;
      5'h07: return 16'h01FF;
      5'h0B: return 16'h8888;
      5'h10: return 16'h8000;
      5'h1A: return 16'h4848;
      default: return 16'h0101;
    endcase
  endfunction

  // PC only returns to zero through reset, so every case starts there;
  // flags and bank are read-only on the bus, so a preamble sets them
  // and the case under test sits at 0x8
  task automatic load(input logic [15:0] i0, i1, input logic [3:0] bk,
                      input logic [11:0] fa, input logic [7:0] f0, w0,
                      input logic [4:0] s0);
    logic [15:0] ab;
    ab = flagPair(s0);
    do_reset();
    u_mem.pmem[0] = {8'h0E, ab[15:8]};
    u_mem.pmem[1] = {8'h0F, ab[7:0]};
    u_mem.pmem[2] = {12'h010, bk};
    u_mem.pmem[3] = {8'h0E, w0};
    u_mem.pmem[4] = i0;
    u_mem.pmem[5] = i1;
    u_mem.dmem[fa] = f0;
  endtask

  // Gap counts clocks from the pc update ending the case to the next one
  task automatic go();
    int n;
    clrPulses = 0;
    popPulses = 0;
    apb(1'b1, `REG_CTRL, 32'h1);
    n = 0;
    while (progAddr !== 21'h8 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    while (progAddr === 21'h8 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    firstPc = progAddr;
    gap = 0;
    while (progAddr === firstPc && gap < 100) begin
      @(posedge ref_clk);
      gap++;
    end
  endtask

  initial begin
    rows = '{
      '{16'h0FFF,12'h020,8'h00,8'h01,5'h00,8'h00,8'h00,5'h07},
      '{16'h0F40,12'h020,8'h00,8'h40,5'h00,8'h80,8'h00,5'h18},
      '{16'h0B5F,12'h020,8'h00,8'hA3,5'h0B,8'h03,8'h00,5'h0B},
      '{16'h0980,12'h020,8'h00,8'h00,5'h0B,8'h80,8'h00,5'h1B},
      '{16'h0AA5,12'h020,8'h00,8'hA5,5'h0B,8'h00,8'h00,5'h0F},
      '{16'h0802,12'h020,8'h00,8'h03,5'h07,8'hFF,8'h00,5'h10},
      '{16'h0E7F,12'h020,8'h00,8'h00,5'h1A,8'h7F,8'h00,5'h1A},
      '{16'h2420,12'h020,8'hC2,8'h17,5'h00,8'hD9,8'hC2,5'h10},
      '{16'h2620,12'h020,8'hC2,8'h17,5'h00,8'h17,8'hD9,5'h10},
      '{16'h2020,12'h020,8'h02,8'h4D,5'h01,8'h50,8'h02,5'h02},
      '{16'h1620,12'h020,8'hC2,8'h17,5'h0B,8'h17,8'h02,5'h0B},
      '{16'h9E20,12'h020,8'hC7,8'h00,5'h1A,8'h00,8'h47,5'h1A},
      '{16'h1681,12'hF81,8'hFF,8'hFF,5'h00,8'hFF,8'h0F,5'h00},
      '{16'hF0BC,12'h020,8'h00,8'h5A,5'h0B,8'h5A,8'h00,5'h0B},
      '{16'h0D10,12'h020,8'h00,8'h12,5'h1A,8'h12,8'h00,5'h1A}
    };
    do_reset();
    for (int a = 0; a <= 40; a += 4) begin
      rd(12'(a), "reset value", 32'h0);
    end
    apb(1'b1, `REG_PC, 32'h10);
    rd(`REG_PC, "read-only pc", 32'h0);
    apb(1'b1, `REG_WORK, 32'h5A);
    rd(`REG_WORK, "work write halted", 32'h5A);
    apb(1'b0, 12'h02C, 32'h0);
    check("unmapped error", 32'h1, {31'h0, lastErr});
    $display("Test register map done");
    foreach (rows[i]) begin
      load(rows[i].op, 16'h0, 4'h0, rows[i].fa, rows[i].f0, rows[i].w0,
           rows[i].s0);
      go();
      check("cycle length", 32'h4, gap);
      rd(`REG_WORK, "work", {24'h0, rows[i].we});
      rd(`REG_STATUS, "status", {27'h0, rows[i].se});
      check("file", {24'h0, rows[i].fe}, {24'h0, u_mem.dmem[rows[i].fa]});
    end
    rd(`REG_PROD, "product", 32'h120);
    $display("Test row table done");
    load(16'h0105, 16'h0, 4'h0, 12'h020, 8'h00, 8'h00, 5'h00);
    go();
    rd(`REG_BANK, "bank", 32'h5);
    load(16'h2720, 16'h0, 4'h2, 12'h220, 8'h01, 8'h01, 5'h00);
    go();
    check("banked file", 32'h2, {24'h0, u_mem.dmem[12'h220]});
    $display("Test bank select done");
    for (int i = 0; i < 4; i++) begin
      load(brOp[i], 16'h0, 4'h0, 12'h020, 8'h00, 8'h00, brSt[i]);
      go();
      check("branch target", brPc[i], {11'h0, firstPc});
      check("branch cycles", brGap[i], gap);
    end
    $display("Test branches done");
    load(16'h0C33, 16'h0, 4'h0, 12'h020, 8'h00, 8'h00, 5'h1A);
    go();
    check("return target", 32'h40, {11'h0, firstPc});
    check("return cycles", 32'h8, gap);
    check("return pop", 32'h1, popPulses);
    rd(`REG_WORK, "return literal", 32'h33);
    apb(1'b1, `REG_WORK, 32'h99);
    rd(`REG_WORK, "work locked in run", 32'h33);
    rd(`REG_STATUS, "return flags", 32'h1A);
    load(16'hEE1A, 16'hF0BC, 4'h0, 12'h020, 8'h00, 8'h5A, 5'h00);
    go();
    rd(`REG_PTR1, "pointer load", 32'hABC);
    rd(`REG_WORK, "pointer second word", 32'h5A);
    $display("Test return and pointer load done");
    // Pointer starts at zero so post-decrement wraps all 21 bits
    for (int m = 0; m < 4; m++) begin
      load(16'h0008 | 16'(m), 16'h0, 4'h0, 12'h020, 8'h00, 8'h00, 5'h00);
      go();
      check("table read cycles", 32'h8, gap);
      rd(`REG_TBL_LATCH, "latch", {24'h0, 8'(m == 3) ^ 8'h5A});
      rd(`REG_TBL_PTR, "table pointer", ptrExp[m]);
    end
    for (int s = 0; s < 2; s++) begin
      load(16'h000D, 16'h0, 4'h0, 12'h020, 8'h00, 8'h00, 5'h00);
      apb(1'b1, `REG_TBL_PTR, 32'h30);
      apb(1'b1, `REG_TBL_LATCH, 32'h3C + 32'(s));
      tableWriteStarted <= (s == 0);
      go();
      check("write cycles", (s == 0) ? 32'h14 : 32'h8, gap);
      check("table memory", 32'h3C + 32'(s), {24'h0, u_mem.tbl[8'h30]});
      rd(`REG_TBL_PTR, "write pointer", 32'h31);
    end
    tableWriteStarted <= 1'b0;
    $display("Test table access done");
    for (int t = 0; t < 3; t++) begin
      load(tmOp[t], 16'h0, 4'h0, 12'hFD6, 8'h10, 8'h01, 5'h00);
      prescalerAssigned <= tmAs[t];
      go();
      check("prescaler clear", tmExp[t], clrPulses);
    end
    $display("Test timer zero done");
    test_done();
  end
endmodule
